// ### logic/drc_read_handler.sv
// Read-type command handler of the background debug controller, with AXI4-Lite registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "drc_defs.svh"
module drc_read_handler (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite register port
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Host byte stream from the link layer
   input wire logic cmd_valid,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic sync_seen,
   output logic ack_pulse,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   // Internal bus read port
   output logic mem_req,
   output logic [23:0] mem_addr,
   output drc_pkg::drc_size_t mem_size,
   input wire logic mem_done,
   input wire logic mem_err,
   input wire logic [31:0] mem_rdata,
   // Trace buffer port
   input wire logic tb_present,
   output logic tb_req,
   output logic tb_half,
   input wire logic tb_done,
   input wire logic [31:0] tb_data,
   // CPU state
   input wire logic active_debug_mode,
   input wire logic wait_for_interrupt_instr,
   input wire logic cpu_stopped,
   input wire logic external_wait_stall,
   input wire logic [23:0] pc_current,
   input wire logic [23:0] pc_next,
   input wire logic pc_wr,
   input wire logic [23:0] pc_wdata,
   // Upper status byte from the rest of the controller
   input wire logic [7:0] status_high
);
   import drc_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Byte count of an operand size
   function automatic logic [2:0] size_bytes(input drc_size_t sz);
      size_bytes = (sz == 2'h0) ? 3'h1 : (sz == 2'h1) ? 3'h2 : 3'h4;
   endfunction : size_bytes

   // Push the low bytes of a word to the top
   function automatic logic [31:0] to_top(input logic [31:0] d, input drc_size_t sz);
      to_top = (sz == 2'h0) ? {d[7:0], 24'h0} : (sz == 2'h1) ? {d[15:0], 16'h0} : d;
   endfunction : to_top

   // ----------------------------------------------------------------
   // Registers and status
   // ----------------------------------------------------------------
   logic [1:0] ctrl; // Acknowledge enable, stop clock keep
   logic [2:0] flags; // Sticky illegal command, no response, illegal access
   logic [2:0] flag_set; // Events from the handler
   logic ack_enable;
   logic stop_clock_keep_bit;
   logic [7:0] debug_status_low_byte;
   logic [15:0] debug_control_status_reg;
   logic bvalid, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [1:0] next_ctrl;
   logic [2:0] next_flags;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic wr_go, rd_go;

   assign ack_enable = ctrl[`DRC_CTRL_ACK_BIT];
   assign stop_clock_keep_bit = ctrl[`DRC_CTRL_KEEP_BIT];
   assign debug_status_low_byte = {ack_enable, stop_clock_keep_bit, active_debug_mode,
                                   2'h0, flags};
   assign debug_control_status_reg = {status_high, debug_status_low_byte};

   // Write takes address and data together, read one at a time
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid;
   assign rd_go = s_axi_arvalid && !rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;

   // Next register values: decode, write-one-to-clear, set beats clear
   always_comb begin
      next_ctrl = ctrl;
      next_flags = flags | flag_set;
      next_bvalid = bvalid && !s_axi_bready;
      next_bresp = bresp;
      next_rvalid = rvalid && !s_axi_rready;
      next_rresp = rresp;
      next_rdata = rdata;
      if (wr_go) begin
         next_bvalid = 1'b1;
         next_bresp = 2'h0;
         if (s_axi_awaddr == `DRC_CTRL_OFS) begin
            if (s_axi_wstrb[0]) next_ctrl = s_axi_wdata[1:0];
         end else if (s_axi_awaddr == `DRC_FLAG_OFS) begin
            if (s_axi_wstrb[0]) next_flags = (flags & ~s_axi_wdata[2:0]) | flag_set;
         end else if (s_axi_awaddr != `DRC_ADDR_OFS) begin
            next_bresp = 2'h3;
         end
      end
      if (rd_go) begin
         next_rvalid = 1'b1;
         next_rresp = 2'h0;
         if (s_axi_araddr == `DRC_CTRL_OFS) begin
            next_rdata = {30'h0, ctrl};
         end else if (s_axi_araddr == `DRC_FLAG_OFS) begin
            next_rdata = {16'h0, debug_control_status_reg};
         end else if (s_axi_araddr == `DRC_ADDR_OFS) begin
            next_rdata = {8'h0, mem_addr};
         end else begin
            next_rdata = 32'h0;
            next_rresp = 2'h3;
         end
      end
   end

   // Register the bus slave state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= `DRC_CTRL_RST;
         flags <= `DRC_FLAG_RST;
         bvalid <= 1'b0;
         bresp <= 2'h0;
         rvalid <= 1'b0;
         rresp <= 2'h0;
         rdata <= 32'h0;
      end else begin
         ctrl <= next_ctrl;
         flags <= next_flags;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   drc_state_t state, next_state;
   drc_kind_t kind, next_kind;
   drc_size_t size, next_size;
   logic [23:0] addr, next_addr; // Stored read address pointer
   logic [1:0] abytes, next_abytes; // Address bytes received
   logic with_st, next_with_st;
   logic rpt_ok, next_rpt_ok; // Repeat-read allowed now
   logic half, next_half; // Second trace longword
   logic [7:0] tmo, next_tmo; // Access timeout count
   logic [31:0] data, next_data;
   logic [23:0] pc_shadow, next_pc_shadow;
   logic pc_held, next_pc_held;
   logic load;
   logic [39:0] load_data;
   logic [2:0] load_cnt;
   logic busy;
   logic pc_stall;
   logic expired;

   assign mem_req = (state == DRC_MEM);
   assign mem_addr = addr;
   assign mem_size = size;
   assign tb_req = (state == DRC_TB);
   assign tb_half = half;
   assign ack_pulse = (state == DRC_ACK) && ack_enable && (kind != DRC_K_STAT)
                      && (kind != DRC_K_BAD);
   assign pc_stall = wait_for_interrupt_instr || external_wait_stall
                     || (cpu_stopped && !stop_clock_keep_bit);
   assign expired = (tmo == `DRC_TIMEOUT_CYC);
   assign load = (state == DRC_ACK);

   // Bytes handed to the sender: optional status byte, then data
   always_comb begin
      load_data = 40'h0;
      load_cnt = 3'h0;
      case (kind)
         DRC_K_MEM, DRC_K_BAD: begin
            if (with_st) begin
               load_data = {debug_status_low_byte, to_top(data, size)};
               load_cnt = size_bytes(size) + 3'h1;
            end else begin
               load_data = {to_top(data, size), 8'h00};
               load_cnt = size_bytes(size);
            end
         end
         DRC_K_TB: begin
            load_data = {data, 8'h00};
            load_cnt = 3'h4;
         end
         DRC_K_PC: begin
            load_data = {data[23:0], 16'h0};
            load_cnt = 3'h3;
         end
         default: begin
            load_data = {debug_control_status_reg, 24'h0};
            load_cnt = 3'h2;
         end
      endcase
   end

   // Next sequencer state
   always_comb begin
      next_state = state;
      next_kind = kind;
      next_size = size;
      next_addr = addr;
      next_abytes = abytes;
      next_with_st = with_st;
      next_rpt_ok = rpt_ok;
      next_half = half;
      next_tmo = 8'h00;
      next_data = data;
      next_pc_shadow = pc_shadow;
      next_pc_held = pc_held && active_debug_mode;
      flag_set = 3'h0;
      if (pc_wr && active_debug_mode) begin
         next_pc_shadow = pc_wdata;
         next_pc_held = 1'b1;
      end
      if (sync_seen) next_rpt_ok = 1'b1;
      case (state)
         DRC_IDLE: begin
            next_half = 1'b0;
            if (cmd_valid) begin
               next_rpt_ok = 1'b0;
               if (rx_byte == `DRC_OP_NOP) begin
                  next_rpt_ok = rpt_ok;
               end else if (rx_byte[7:4] == 4'h3 && rx_byte[1] == 1'b0
                            && rx_byte[3:2] != 2'h3) begin
                  next_kind = DRC_K_MEM;
                  next_size = rx_byte[3:2];
                  next_with_st = rx_byte[0];
                  next_abytes = 2'h0;
                  next_state = DRC_ADDR;
               end else if (rx_byte == `DRC_OP_SAME || rx_byte == `DRC_OP_SAME_WS) begin
                  next_with_st = rx_byte[0];
                  if (rpt_ok) begin
                     next_kind = DRC_K_MEM;
                     next_state = DRC_MEM;
                  end else begin
                     next_kind = DRC_K_BAD;
                     next_data = {4{`DRC_FAIL_BYTE}};
                     flag_set[`DRC_FLAG_ILLEGAL_COMMAND_FLAG_BIT] = 1'b1;
                     next_state = DRC_ACK;
                  end
               end else if (rx_byte == `DRC_OP_STATUS) begin
                  next_kind = DRC_K_STAT;
                  next_state = DRC_ACK;
               end else if (rx_byte == `DRC_OP_TRACE) begin
                  next_kind = DRC_K_TB;
                  next_data = {4{`DRC_NO_TRACE_BYTE}};
                  next_state = tb_present ? DRC_TB : DRC_ACK;
               end else if (rx_byte == `DRC_OP_PC) begin
                  next_kind = DRC_K_PC;
                  next_state = DRC_PC;
               end
            end
         end
         DRC_ADDR: begin
            if (rx_valid) begin
               next_addr = {addr[15:0], rx_byte};
               next_abytes = abytes + 2'h1;
               if (abytes == 2'h2) begin
                  // Align longword reads before the access starts so the bus never sees their low bits
                  if (size == 2'h2) next_addr[1:0] = 2'h0;
                  next_state = DRC_MEM;
               end
            end
         end
         DRC_MEM: begin
            if (size == 2'h2) next_addr = {addr[23:2], 2'h0};
            next_tmo = tmo + 8'h01;
            if (mem_done) begin
               next_data = mem_err ? {4{`DRC_FAIL_BYTE}} : mem_rdata;
               flag_set[`DRC_FLAG_ILLEGAL_ACCESS_FLAG_BIT] = mem_err;
               next_rpt_ok = 1'b1;
               next_state = DRC_ACK;
            end else if (expired) begin
               next_data = {4{`DRC_FAIL_BYTE}};
               flag_set[`DRC_FLAG_NO_RESPONSE_FLAG_BIT] = 1'b1;
               next_rpt_ok = 1'b1;
               next_state = DRC_ACK;
            end
         end
         DRC_TB: begin
            next_tmo = tmo + 8'h01;
            if (tb_done) begin
               next_data = tb_data;
               next_state = DRC_ACK;
            end else if (expired) begin
               next_data = {4{`DRC_FAIL_BYTE}};
               flag_set[`DRC_FLAG_NO_RESPONSE_FLAG_BIT] = 1'b1;
               next_state = DRC_ACK;
            end
         end
         DRC_PC: begin
            next_tmo = tmo + 8'h01;
            if (!pc_stall) begin
               if (active_debug_mode) begin
                  next_data = {8'h0, pc_held ? pc_shadow : pc_next};
               end else if (cpu_stopped) begin
                  next_data = {8'h0, pc_next};
               end else begin
                  next_data = {8'h0, pc_current};
               end
               next_state = DRC_ACK;
            end else if (expired) begin
               next_data = {4{`DRC_FAIL_BYTE}};
               flag_set[`DRC_FLAG_NO_RESPONSE_FLAG_BIT] = 1'b1;
               next_state = DRC_ACK;
            end
         end
         DRC_ACK: begin
            next_state = DRC_SEND;
         end
         default: begin
            if (!busy) begin
               if (kind == DRC_K_TB && !half) begin
                  next_half = 1'b1;
                  next_state = tb_present ? DRC_TB : DRC_ACK;
               end else begin
                  next_state = DRC_IDLE;
               end
            end
         end
      endcase
   end

   // Register the sequencer state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= DRC_IDLE;
         kind <= DRC_K_MEM;
         size <= 2'h0;
         addr <= 24'h0;
         abytes <= 2'h0;
         with_st <= 1'b0;
         rpt_ok <= 1'b0;
         half <= 1'b0;
         tmo <= 8'h00;
         data <= 32'h0;
         pc_shadow <= 24'h0;
         pc_held <= 1'b0;
      end else begin
         state <= next_state;
         kind <= next_kind;
         size <= next_size;
         addr <= next_addr;
         abytes <= next_abytes;
         with_st <= next_with_st;
         rpt_ok <= next_rpt_ok;
         half <= next_half;
         tmo <= next_tmo;
         data <= next_data;
         pc_shadow <= next_pc_shadow;
         pc_held <= next_pc_held;
      end
   end

   // Byte sender toward the link
   drc_tx_shift drc_tx_shift_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(load),
      .load_data(load_data),
      .load_cnt(load_cnt),
      .busy(busy),
      .tx_valid(tx_valid),
      .tx_byte(tx_byte),
      .tx_ready(tx_ready)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ack_then_data;
      ack_pulse ##1 tx_valid;
   endsequence

   chk_long_align: assert property (mem_req && mem_size == 2'h2
      |-> mem_addr[1:0] == 2'h0) else $error("longword read not aligned");
   chk_status_first: assert property (load && kind == DRC_K_MEM && with_st
      |=> tx_byte == $past(debug_status_low_byte)) else $error("status byte not first");
   chk_ack_lead: assert property (ack_pulse |-> s_ack_then_data)
      else $error("acknowledge not followed by data");
   chk_trace_empty: assert property (state == DRC_IDLE && cmd_valid
      && rx_byte == `DRC_OP_TRACE && !tb_present |=> ##1 tx_byte == 8'h00)
      else $error("missing trace buffer gave data");
   chk_same_illegal: assert property (state == DRC_IDLE && cmd_valid
      && rx_byte == `DRC_OP_SAME && !rpt_ok && !sync_seen
      |=> ##1 flags[`DRC_FLAG_ILLEGAL_COMMAND_FLAG_BIT]) else $error("bad repeat-read not flagged");
   chk_nop_addr: assert property (state == DRC_IDLE && cmd_valid
      && rx_byte == `DRC_OP_NOP |=> $stable(addr)) else $error("no-op moved address");
   chk_status_mode: assert property (state == DRC_IDLE && cmd_valid
      && rx_byte == `DRC_OP_STATUS |=> ##1 tx_valid && tx_byte == status_high)
      else $error("status read not served");
   chk_pc_timeout: assert property (state == DRC_PC && pc_stall && expired
      |=> data == {4{8'hee}} ##1 flags[`DRC_FLAG_NO_RESPONSE_FLAG_BIT])
      else $error("PC timeout not reported");
endmodule : drc_read_handler

// ### logic/drc_defs.svh
// Offsets, opcodes, field positions, reset values and timing counts of the read handler
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define DRC_OP_RD_B_WS 8'h31
`define DRC_OP_RD_W_WS 8'h35
`define DRC_OP_RD_L_WS 8'h39
`define DRC_OP_SAME 8'h54
`define DRC_OP_SAME_WS 8'h55
`define DRC_OP_TRACE 8'h07
`define DRC_OP_STATUS 8'h2d
`define DRC_OP_PC 8'h01
`define DRC_OP_NOP 8'h00
// ----------------------------------------------------------------
// Data patterns
// ----------------------------------------------------------------
`define DRC_FAIL_BYTE 8'hee
`define DRC_NO_TRACE_BYTE 8'h00
// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define DRC_CTRL_OFS 12'h000
`define DRC_FLAG_OFS 12'h004
`define DRC_ADDR_OFS 12'h008
`define DRC_CTRL_ACK_BIT 0
`define DRC_CTRL_KEEP_BIT 1
`define DRC_CTRL_RST 2'h0
`define DRC_FLAG_RST 3'h0
`define DRC_FLAG_ILLEGAL_COMMAND_FLAG_BIT 0
`define DRC_FLAG_NO_RESPONSE_FLAG_BIT 1
`define DRC_FLAG_ILLEGAL_ACCESS_FLAG_BIT 2
// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define DRC_TIMEOUT_CYC 8'hff
`endif

// ### logic/drc_pkg.sv
// Types shared by the read handler modules
package drc_pkg;
   // Handler sequence states
   typedef enum logic [2:0] {
      DRC_IDLE, DRC_ADDR, DRC_MEM, DRC_TB, DRC_PC, DRC_ACK, DRC_SEND
   } drc_state_t;
   // Operand size field
   typedef logic [1:0] drc_size_t;
   // Kind of read being served
   typedef enum logic [2:0] {
      DRC_K_MEM, DRC_K_TB, DRC_K_PC, DRC_K_STAT, DRC_K_BAD
   } drc_kind_t;
endpackage : drc_pkg

// ### logic/drc_tx_shift.sv
// Byte sender that plays out up to five loaded bytes, first byte from the top
`timescale 1ns/100ps
module drc_tx_shift (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Load side
   input wire logic load,
   input wire logic [39:0] load_data,
   input wire logic [2:0] load_cnt,
   output logic busy,
   // Byte side toward the link serializer
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready
);
   // ----------------------------------------------------------------
   // Shift state
   // ----------------------------------------------------------------
   logic [39:0] sreg; // Bytes still to go, next on top
   logic [2:0] cnt; // Bytes still to go
   logic [39:0] next_sreg;
   logic [2:0] next_cnt;

   // Handshake outputs follow the count directly
   assign busy = (cnt != 3'h0);
   assign tx_valid = busy;
   assign tx_byte = sreg[39:32];

   // Next shift state: load wins, else move one byte per accepted handshake
   always_comb begin
      next_sreg = sreg;
      next_cnt = cnt;
      if (load) begin
         next_sreg = load_data;
         next_cnt = load_cnt;
      end else if (busy && tx_ready) begin
         next_sreg = {sreg[31:0], 8'h00};
         next_cnt = cnt - 3'h1;
      end
   end

   // Register the shift state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sreg <= 40'h0000000000;
         cnt <= 3'h0;
      end else begin
         sreg <= next_sreg;
         cnt <= next_cnt;
      end
   end
endmodule : drc_tx_shift

// ### sim/drc_host_model.sv
// Debug host model: sends commands, gathers answer bytes
`timescale 1ns/100ps
`include "drc_defs.svh"
module drc_host_model (
   // Clock
   input wire logic aclk,
   // Host to handler
   output logic cmd_valid,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic tx_ready,
   // Handler to host
   input wire logic ack_pulse,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte
);
   logic [7:0] got[$]; // Answer bytes in arrival order
   int acks = 0; // Acknowledges seen
   logic slow = 1'b0; // Stall every other cycle
   logic [23:0] addr = 24'h000123; // Read address sent
   logic [7:0] op_sent = 8'h00; // Command of the running exchange
   int gap = 0; // Cycles left in the pause between trace longwords
   initial begin
      cmd_valid = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b1;
   end
   // Gather bytes, count acknowledges
   always @(posedge aclk) begin
      if (gap > 0) gap--;
      if (tx_valid && tx_ready) begin
         got.push_back(tx_byte);
         // Without acknowledges, pause 16 cycles after the first trace longword
         if (op_sent == `DRC_OP_TRACE && acks == 0 && got.size() == 4) gap = 16;
      end
      tx_ready <= (gap > 0) ? 1'b0 : (slow ? ~tx_ready : 1'b1);
      if (ack_pulse) acks++;
   end
   // Command byte, then address bytes
   task automatic send(input logic [7:0] op, input int na);
      got.delete();
      acks = 0;
      op_sent = op;
      @(posedge aclk);
      cmd_valid <= 1'b1;
      rx_byte <= op;
      for (int i = 0; i < na; i++) begin
         @(posedge aclk);
         cmd_valid <= 1'b0;
         rx_valid <= 1'b1;
         rx_byte <= addr[23-8*i -: 8];
      end
      @(posedge aclk);
      cmd_valid <= 1'b0;
      rx_valid <= 1'b0;
   endtask : send
endmodule : drc_host_model

// ### sim/drc_read_handler_tb.sv
// Self-checking bench of the read handler
`timescale 1ns/100ps
`include "drc_defs.svh"
module drc_read_handler_tb;
   import drc_pkg::*;
   // Table row: command, cpu state, answer
   typedef struct {logic [7:0] op; logic [3:0] cpu; int n; logic [7:0] b0, bl; int ak;} drc_row_t;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic cmd_valid, rx_valid, tx_ready, ack_pulse, tx_valid, mem_req, tb_req, tb_half;
   logic [7:0] rx_byte, tx_byte, status_high = 8'h5a;
   logic sync_seen = 1'b0, mem_done = 1'b0, mem_err = 1'b0, tb_present = 1'b1, tb_done = 1'b0;
   logic [23:0] mem_addr, last_addr, pc_wdata = 24'h0;
   logic [23:0] pc_current = 24'h00abcd, pc_next = 24'h00abd0;
   drc_size_t mem_size;
   logic [31:0] mem_rdata = 32'h11223344, tb_data = 32'h0;
   logic active_debug_mode = 1'b0, wait_for_interrupt_instr = 1'b0, cpu_stopped = 1'b0;
   logic external_wait_stall = 1'b0, pc_wr = 1'b0;
   int failures = 0, check_count = 0;
   // Cpu bits: debug mode, wait, stall, stopped
   drc_row_t rows[14] = '{
      '{8'h31, 4'h0, 2, 8'h80, 8'h44, 1},
      '{8'h35, 4'h0, 3, 8'h80, 8'h44, 1},
      '{8'h39, 4'h0, 5, 8'h80, 8'h44, 1},
      '{8'h00, 4'h0, 0, 8'h00, 8'h00, 0},
      '{8'h55, 4'h0, 5, 8'h80, 8'h44, 1},
      '{8'h54, 4'h0, 4, 8'h11, 8'h44, 1},
      '{8'h2d, 4'h0, 2, 8'h5a, 8'h80, 0},
      '{8'h54, 4'h0, 4, 8'hee, 8'hee, 0},
      '{8'h01, 4'h8, 3, 8'h00, 8'hd0, 1},
      '{8'h01, 4'h0, 3, 8'h00, 8'hcd, 1},
      '{8'h01, 4'h4, 3, 8'hee, 8'hee, -1},
      '{8'h01, 4'h2, 3, 8'hee, 8'hee, -1},
      '{8'h01, 4'h1, 3, 8'hee, 8'hee, -1},
      '{8'h07, 4'h0, 8, 8'h01, 8'h0d, 2}};
   always #20 aclk = ~aclk;
   drc_read_handler drc_read_handler_i (.*);
   drc_host_model drc_host_model_i (.*);
   // Bus and trace answer one cycle after request
   always @(posedge aclk) begin
      mem_done <= mem_req && !mem_done;
      tb_done <= tb_req && !tb_done;
      tb_data <= tb_half ? 32'hcafef00d : 32'h01234567;
      if (mem_req) last_addr <= mem_addr;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   // Give up on a wait that ran out
   task automatic bound(input int k);
      if (k >= 600) begin
         failures++;
         print_verdict();
      end
   endtask : bound
   task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int k = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_awready && ++k < 600);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_bvalid && ++k < 600);
      bound(k);
      chk("bresp", s_axi_bresp, er);
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      int k = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready && ++k < 600);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid && ++k < 600);
      bound(k);
      chk("rdata", s_axi_rdata & m, e);
      chk("rresp", s_axi_rresp, 2'h0);
      s_axi_rready <= 1'b0;
   endtask : axr
   // One command, then count and ends of the answer
   task automatic run(input logic [7:0] op, int n, logic [7:0] b0, logic [7:0] bl, int ak);
      int k = 0;
      drc_host_model_i.send(op, (op[7:4] == 4'h3) ? 3 : 0);
      while (drc_host_model_i.got.size() < n && ++k < 600) @(posedge aclk);
      bound(k);
      repeat (8) @(posedge aclk);
      chk("count", drc_host_model_i.got.size(), n);
      if (n > 0) chk("first", drc_host_model_i.got[0], b0);
      if (n > 0) chk("last", drc_host_model_i.got[n-1], bl);
      if (ak >= 0) chk("acks", drc_host_model_i.acks, ak);
   endtask : run
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      chk("tx_valid", tx_valid, 1'b0);
      chk("mem_req", mem_req, 1'b0);
      axr(`DRC_CTRL_OFS, 32'h3, 32'h0);
      axw(`DRC_CTRL_OFS, 32'h1, 2'h0);
      axr(`DRC_CTRL_OFS, 32'h3, 32'h1);
      axw(12'h100, 32'h0, 2'h3);
      foreach (rows[i]) begin
         {active_debug_mode, wait_for_interrupt_instr, external_wait_stall, cpu_stopped} <=
            rows[i].cpu;
         run(rows[i].op, rows[i].n, rows[i].b0, rows[i].bl, rows[i].ak);
         if (rows[i].op == 8'h39) chk("addr", last_addr, 24'h000120);
         if (rows[i].op == 8'h39) chk("size", mem_size, 2'h2);
      end
      axr(`DRC_FLAG_OFS, 32'h7, 32'h3);
      axw(`DRC_FLAG_OFS, 32'h7, 2'h0);
      axr(`DRC_FLAG_OFS, 32'h7, 32'h0);
      axr(`DRC_ADDR_OFS, 32'hffffff, 32'h120);
      axw(`DRC_CTRL_OFS, 32'h3, 2'h0);
      cpu_stopped <= 1'b1;
      run(8'h01, 3, 8'h00, 8'hd0, 1);
      cpu_stopped <= 1'b0;
      active_debug_mode <= 1'b1;
      pc_wdata <= 24'h00beef;
      pc_wr <= 1'b1;
      @(posedge aclk);
      pc_wr <= 1'b0;
      run(8'h01, 3, 8'h00, 8'hef, 1);
      tb_present <= 1'b0;
      run(8'h07, 8, 8'h00, 8'h00, 2);
      drc_host_model_i.slow = 1'b1;
      sync_seen <= 1'b1;
      @(posedge aclk);
      sync_seen <= 1'b0;
      run(8'h54, 4, 8'h11, 8'h44, 1);
      // Reset in mid-run: control, pointer and sender return to rest
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk("tx_valid", tx_valid, 1'b0);
      axr(`DRC_CTRL_OFS, 32'h3, 32'h0);
      axr(`DRC_ADDR_OFS, 32'hffffff, 32'h0);
      // Acknowledges now off: host pauses between trace longwords
      run(8'h07, 8, 8'h00, 8'h00, 0);
      print_verdict();
   end
endmodule : drc_read_handler_tb
